// File: verilog/scw_map.vh
`ifndef SCW_MAP_VH
`define SCW_MAP_VH

// word offsets within the memory map (axi byte address = 4 * offset)
`define SCW_OFS_REQ_CLR 11'h480
`define SCW_AXI_ADDR_W 13

// map regions, taken from offset bits 10:7
`define SCW_RGN_CTRL 4'h0
`define SCW_RGN_IMAGE 4'h2
`define SCW_RGN_AUX_FIRST 4'h3
`define SCW_RGN_AUX_LAST 4'h9

// decoded targets
`define SCW_TGT_CTRL 4'h0
`define SCW_TGT_IMAGE 4'h1
`define SCW_TGT_AUX 4'h2
`define SCW_TGT_REQ_CLR 4'h3
`define SCW_TGT_NONE 4'hf

// control word fields
`define SCW_CMD_LSB 0
`define SCW_CMD_MSB 3
`define SCW_ACF_BIT 4
`define SCW_ARF_BIT 5
`define SCW_SREQ_BIT 8
`define SCW_MISS1_BIT 10
`define SCW_MISS3_BIT 11
`define SCW_CNT_LSB 12
`define SCW_CNT_MSB 14
`define SCW_CTRL_RESET 16'h0000

// command codes
`define SCW_CMD_IMAGE 4'h0
`define SCW_CMD_AUX_LAST_ROUND 4'h6
`define SCW_CMD_AUX7 4'h7
`define SCW_CMD_IMAGE_ONCE 4'h8
`define SCW_CMD_ZERO_FIRST 4'h9
`define SCW_CMD_ZERO_LAST 4'he
`define SCW_AUX7_INDEX 3'h6

// missed-reply counting
`define SCW_CNT_MAX 3'h7
`define SCW_CNT_THREE 3'h3

// first-miss pulse length
`define SCW_CLK_PERIOD_NS 10
`define SCW_PULSE_NS 1000
`define SCW_PULSE_CYCLES (`SCW_PULSE_NS / `SCW_CLK_PERIOD_NS)

// axi responses
`define SCW_RESP_OKAY 2'h0
`define SCW_RESP_SLVERR 2'h2

`endif

// File: verilog/scw_ctrl_word.v
// Contract
// - host writes 4-bit command into control word bits 0-3; scans use it
// - reply goes to image (0,8), aux 1-6 (1-6, 9-14), aux 7 (7,15)
// - commands 1-6 without auto-clear or auto-round repeat every scan until host rewrites
// - auto-clear without auto-round with command 1-6 returns command and flag to 0 after success
// - auto-round advances command through 0..6 on each successful scan
// - command 0 with both flags steps 1..6 once, then stops at 0
// - clearing and advancing happen only on scans whose link succeeded
// - commands 7, 8, 15 return to 0 after one success, ignoring auto-clear
// - commands 9-14 return to 0 and zero the matching aux word
// - missed-reply count increments per miss, saturating at 7
// - a missed reply leaves the image word unchanged
// - any reply clears count and both miss flags
// - a single lost reply shows count and flag 1 for that scan only
// - reply with service request sets bit 8 of the control word
// - executing an individual-function command clears the service request flag
// - request pin goes high on reply carrying a service request
// - writing 00h to request-clear register drives request pin low
// - any-miss flag rising gives a fixed-length first-miss pulse
// - control word at twice satellite number, image word 100h above
// - missed-reply count held in control word bits 12-14
// - any-miss flag bit 10 set while count is one or more
// - three-miss flag bit 11 set while count is three or more
`timescale 1ns/10ps
`default_nettype none
`include "scw_map.vh"

module scw_ctrl_word #(
    parameter [15:0] PULSE_CYCLES = `SCW_PULSE_CYCLES
) (
    // clock, reset, enable
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    // axi4-lite write address and data
    input wire [`SCW_AXI_ADDR_W-1:0] s_axi_awaddr_i,
    input wire [2:0] s_axi_awprot_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    // axi4-lite read
    input wire [`SCW_AXI_ADDR_W-1:0] s_axi_araddr_i,
    input wire [2:0] s_axi_arprot_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    // scan engine: command lookup
    input wire [5:0] scan_sel_i,
    output reg [3:0] scan_cmd_o,
    // scan engine: end of one satellite's scan
    input wire scan_done_i,
    input wire [5:0] scan_sat_i,
    input wire scan_reply_i,
    input wire [15:0] scan_data_i,
    input wire scan_sreq_i,
    // pins
    output reg service_request_o,
    output wire first_miss_pulse_pin_o
);

    reg [1:0] rst_sync;
    wire rst_n;
    reg [15:0] ctrl_mem [0:63];
    reg [15:0] image_mem [0:63];
    reg [15:0] aux_mem [0:511];
    reg aw_held, w_held;
    reg [10:0] wr_ofs;
    reg [31:0] wr_data;
    reg [3:0] wr_strb;
    reg [15:0] pulse_cnt;
    wire [10:0] rd_ofs;
    wire [3:0] rd_tgt, wr_tgt, scan_cmd;
    wire [5:0] wr_sat, rd_sat;
    wire [2:0] wr_aux, rd_aux, store_aux_idx;
    wire [15:0] scan_old, scan_new, store_val;
    wire do_write, scan_ev, store_image, store_aux, first_miss, req_set, req_clr;
    reg [15:0] rd_word;
    integer i;

    // decode a word offset into a target class
    function [3:0] decode;
        input [10:0] ofs;
        reg [3:0] rgn;
        reg [5:0] sat;
        begin
            rgn = ofs[10:7];
            sat = ofs[6:1];
            decode = `SCW_TGT_NONE;
            if (ofs[0] == 1'b0)
            begin
                if (ofs == `SCW_OFS_REQ_CLR)
                    decode = `SCW_TGT_REQ_CLR;
                else if (sat != 6'h00)
                begin
                    if (rgn == `SCW_RGN_CTRL)
                        decode = `SCW_TGT_CTRL;
                    else if (rgn == `SCW_RGN_IMAGE)
                        decode = `SCW_TGT_IMAGE;
                    else if (rgn >= `SCW_RGN_AUX_FIRST && rgn <= `SCW_RGN_AUX_LAST)
                        decode = `SCW_TGT_AUX;
                end
            end
        end
    endfunction
    // aux area index 0..6 from the offset region
    function [2:0] aux_index;
        input [10:0] ofs;
        reg [3:0] d;
        begin
            d = ofs[10:7] - `SCW_RGN_AUX_FIRST;
            aux_index = d[2:0];
        end
    endfunction
    // control word after one scan of its satellite
    function [15:0] ctrl_next;
        input [15:0] w;
        input reply;
        input sreq;
        reg [3:0] cmd;
        reg acf, auto_round_flag, sflag;
        reg [2:0] cnt;
        begin
            cmd = w[`SCW_CMD_MSB:`SCW_CMD_LSB];
            acf = w[`SCW_ACF_BIT];
            auto_round_flag = w[`SCW_ARF_BIT];
            sflag = w[`SCW_SREQ_BIT];
            cnt = w[`SCW_CNT_MSB:`SCW_CNT_LSB];
            if (reply)
            begin
                cnt = 3'h0;
                if (cmd != `SCW_CMD_IMAGE && cmd != `SCW_CMD_IMAGE_ONCE)
                    sflag = 1'b0;
                if (sreq)
                    sflag = 1'b1;
                if (cmd == `SCW_CMD_IMAGE)
                begin
                    if (auto_round_flag)
                        cmd = 4'h1;
                end
                else if (cmd <= `SCW_CMD_AUX_LAST_ROUND)
                begin
                    if (auto_round_flag)
                    begin
                        if (cmd == `SCW_CMD_AUX_LAST_ROUND)
                        begin
                            cmd = `SCW_CMD_IMAGE;
                            if (acf)
                            begin
                                acf = 1'b0;
                                auto_round_flag = 1'b0;
                            end
                        end
                        else
                            cmd = cmd + 4'h1;
                    end
                    else if (acf)
                    begin
                        cmd = `SCW_CMD_IMAGE;
                        acf = 1'b0;
                    end
                end
                else
                    cmd = `SCW_CMD_IMAGE;
            end
            else if (cnt != `SCW_CNT_MAX)
                cnt = cnt + 3'h1;
            ctrl_next = {1'b0, cnt, (cnt >= `SCW_CNT_THREE), (cnt != 3'h0), 1'b0, sflag,
                         w[7:6], auto_round_flag, acf, cmd};
        end
    endfunction
    // reset release through two flops
    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];
    // axi write channels are taken independently, then committed together
    assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
    assign do_write = aw_held && w_held && !s_axi_bvalid_o;
    assign wr_tgt = decode(wr_ofs);
    assign wr_sat = wr_ofs[6:1];
    assign wr_aux = aux_index(wr_ofs);
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_ofs <= 11'h000;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `SCW_RESP_OKAY;
        end
        else if (ce_i)
        begin
            if (s_axi_awvalid_i && s_axi_awready_o)
            begin
                aw_held <= 1'b1;
                wr_ofs <= s_axi_awaddr_i[12:2];
            end
            if (s_axi_wvalid_i && s_axi_wready_o)
            begin
                w_held <= 1'b1;
                wr_data <= s_axi_wdata_i;
                wr_strb <= s_axi_wstrb_i;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (wr_tgt == `SCW_TGT_NONE) ? `SCW_RESP_SLVERR : `SCW_RESP_OKAY;
            end
            else if (s_axi_bvalid_o && s_axi_bready_i)
                s_axi_bvalid_o <= 1'b0;
        end
    end
    // read: one cycle from address to data
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign rd_ofs = s_axi_araddr_i[12:2];
    assign rd_tgt = decode(rd_ofs);
    assign rd_sat = rd_ofs[6:1];
    assign rd_aux = aux_index(rd_ofs);
    // satellite number picks the word in each area
    always @*
    begin
        case (rd_tgt)
            `SCW_TGT_CTRL: rd_word = ctrl_mem[rd_sat];
            `SCW_TGT_IMAGE: rd_word = image_mem[rd_sat];
            `SCW_TGT_AUX: rd_word = aux_mem[{rd_aux, rd_sat}];
            default: rd_word = 16'h0000;
        endcase
    end

    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `SCW_RESP_OKAY;
        end
        else if (ce_i)
        begin
            if (s_axi_arvalid_i && s_axi_arready_o)
            begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= {16'h0000, rd_word};
                s_axi_rresp_o <= (rd_tgt == `SCW_TGT_NONE) ? `SCW_RESP_SLVERR : `SCW_RESP_OKAY;
            end
            else if (s_axi_rvalid_o && s_axi_rready_i)
                s_axi_rvalid_o <= 1'b0;
        end
    end
    // scan completion for one satellite
    assign scan_ev = scan_done_i && (scan_sat_i != 6'h00);
    assign scan_old = ctrl_mem[scan_sat_i];
    assign scan_new = ctrl_next(scan_old, scan_reply_i, scan_sreq_i);
    assign scan_cmd = scan_old[`SCW_CMD_MSB:`SCW_CMD_LSB];
    // reply data routing, only on a reply
    assign store_image = scan_ev && scan_reply_i &&
                         (scan_cmd == `SCW_CMD_IMAGE || scan_cmd == `SCW_CMD_IMAGE_ONCE);
    assign store_aux = scan_ev && scan_reply_i && !store_image;
    assign store_aux_idx = (scan_cmd[2:0] == 3'h7) ? `SCW_AUX7_INDEX : (scan_cmd[2:0] - 3'h1);
    assign store_val = (scan_cmd >= `SCW_CMD_ZERO_FIRST && scan_cmd <= `SCW_CMD_ZERO_LAST) ?
                       16'h0000 : scan_data_i;
    // control words: host writes only bits 0-7 and wins them on a clash; the scan rewrites all 16 bits
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (i = 0; i < 64; i = i + 1)
                ctrl_mem[i] <= `SCW_CTRL_RESET;
        end
        else if (ce_i)
        begin
            if (scan_ev)
                ctrl_mem[scan_sat_i] <= scan_new;
            if (do_write && wr_tgt == `SCW_TGT_CTRL && wr_strb[0])
            begin
                if (scan_ev && scan_sat_i == wr_sat)
                    ctrl_mem[wr_sat] <= {scan_new[15:8], wr_data[7:0]};
                else
                    ctrl_mem[wr_sat] <= {ctrl_mem[wr_sat][15:8], wr_data[7:0]};
            end
        end
    end
    // data areas: a reply landing on the same word as a host write wins
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (i = 0; i < 64; i = i + 1)
                image_mem[i] <= 16'h0000;
            for (i = 0; i < 512; i = i + 1)
                aux_mem[i] <= 16'h0000;
        end
        else if (ce_i)
        begin
            if (do_write && wr_tgt == `SCW_TGT_IMAGE)
            begin
                if (wr_strb[0])
                    image_mem[wr_sat][7:0] <= wr_data[7:0];
                if (wr_strb[1])
                    image_mem[wr_sat][15:8] <= wr_data[15:8];
            end
            if (do_write && wr_tgt == `SCW_TGT_AUX)
            begin
                if (wr_strb[0])
                    aux_mem[{wr_aux, wr_sat}][7:0] <= wr_data[7:0];
                if (wr_strb[1])
                    aux_mem[{wr_aux, wr_sat}][15:8] <= wr_data[15:8];
            end
            if (store_image)
                image_mem[scan_sat_i] <= scan_data_i;
            if (store_aux)
                aux_mem[{store_aux_idx, scan_sat_i}] <= store_val;
        end
    end
    // command lookup for the scan engine
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            scan_cmd_o <= 4'h0;
        else if (ce_i)
            scan_cmd_o <= ctrl_mem[scan_sel_i][`SCW_CMD_MSB:`SCW_CMD_LSB];
    end
    // request pin set on a requesting reply
    assign req_set = scan_ev && scan_reply_i && scan_sreq_i;
    assign req_clr = do_write && wr_tgt == `SCW_TGT_REQ_CLR && wr_strb[0] &&
                     wr_data[7:0] == 8'h00;

    // a set in the same cycle as the clear wins, so no request is lost
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            service_request_o <= 1'b0;
        else if (ce_i)
        begin
            if (req_set)
                service_request_o <= 1'b1;
            else if (req_clr)
                service_request_o <= 1'b0;
        end
    end

    assign first_miss = scan_ev && !scan_reply_i && !scan_old[`SCW_MISS1_BIT];

    // pulse restarts on each new event
    always @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            pulse_cnt <= 16'h0000;
        else if (ce_i)
        begin
            if (first_miss)
                pulse_cnt <= PULSE_CYCLES;
            else if (pulse_cnt != 16'h0000)
                pulse_cnt <= pulse_cnt - 16'h0001;
        end
    end
    assign first_miss_pulse_pin_o = (pulse_cnt != 16'h0000);

endmodule
`default_nettype wire

// File: verif/scw_sat_model.sv
`timescale 1ns/10ps
`default_nettype none
module scw_sat_model (
    // clock, reset, bench request
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic go_i,
    input wire logic [5:0] sat_i,
    input wire logic alive_i,
    input wire logic sreq_i,
    input wire logic slow_i,
    // scan port of the block
    input wire logic [3:0] scan_cmd_i,
    output logic [5:0] scan_sat_o,
    output logic scan_done_o,
    output logic scan_reply_o,
    output logic [15:0] scan_data_o,
    output logic scan_sreq_o,
    output logic busy_o
);
    logic [1:0] st;
    assign busy_o = (st != 2'h0) || scan_done_o;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st <= 2'h0;
            scan_sat_o <= 6'h00;
            scan_done_o <= 1'h0;
            scan_reply_o <= 1'h0;
            scan_data_o <= 16'h0000;
            scan_sreq_o <= 1'h0;
        end
        else
        begin
            scan_done_o <= 1'h0;
            // data lines toggle outside a reply so a stale word never looks valid
            scan_data_o <= ~scan_data_o;
            if (st == 2'h0 && go_i)
            begin
                scan_sat_o <= sat_i;
                st <= slow_i ? 2'h3 : 2'h1;
            end
            else if (st == 2'h3)
                st <= 2'h1;
            else if (st == 2'h1)
                st <= 2'h2;
            else if (st == 2'h2)
            begin
                scan_done_o <= 1'h1;
                scan_reply_o <= alive_i;
                scan_sreq_o <= alive_i && sreq_i;
                if (alive_i)
                    scan_data_o <= {scan_cmd_i, 6'h00, scan_sat_o};
                st <= 2'h0;
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/scw_chk.sv
`timescale 1ns/10ps
`default_nettype none
module scw_chk #(
    parameter int PULSE_CYCLES = 100
) (
    // clock, reset and enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // register bus
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    // scan side and pins
    input wire logic scan_done_i,
    input wire logic [5:0] scan_sat_i,
    input wire logic scan_reply_i,
    input wire logic scan_sreq_i,
    input wire logic service_request_o,
    input wire logic first_miss_pulse_pin_o
);
    logic [15:0] quiet;
    logic [15:0] run;
    wire scan_ok = ce_i && scan_done_i && (scan_sat_i != 6'h00);
    // cycles since the last miss, saturating so it never wraps back into range
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            quiet <= 16'hffff;
            run <= 16'h0000;
        end
        else if (ce_i)
        begin
            quiet <= (scan_ok && !scan_reply_i) ? 16'h0000 :
                (quiet == 16'hffff) ? quiet : quiet + 16'h0001;
            run <= first_miss_pulse_pin_o ? run + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_wr_take;
        ce_i && s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence s_req_reply;
        scan_ok && scan_reply_i && scan_sreq_i;
    endsequence
    a_req_pin_set: assert property (s_req_reply |=> service_request_o)
        else $error("request pin not raised");
    a_req_pin_cause: assert property (!service_request_o &&
        !(scan_ok && scan_reply_i && scan_sreq_i) |=> !service_request_o)
        else $error("request pin rose without request reply");
    a_pulse_cause: assert property ($rose(first_miss_pulse_pin_o) |->
        $past(scan_ok && !scan_reply_i)) else $error("pulse without a miss");
    a_pulse_len: assert property ($fell(first_miss_pulse_pin_o) |->
        run >= PULSE_CYCLES) else $error("first miss pulse too short");
    a_pulse_end: assert property (quiet >= PULSE_CYCLES |->
        !first_miss_pulse_pin_o) else $error("first miss pulse too long");
    a_wr_resp: assert property (s_wr_take |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
        else $error("write response timing");
    a_wr_release: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
        !s_axi_bvalid_o) else $error("write response not released");
    a_rd_resp: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
        s_axi_rvalid_o && s_axi_rdata_o[31:16] == 16'h0000)
        else $error("read answer late or upper half set");
endmodule
bind scw_ctrl_word scw_chk #(.PULSE_CYCLES(PULSE_CYCLES)) chk_u (
    .clk_i, .rst_n_i, .ce_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .scan_done_i, .scan_sat_i,
    .scan_reply_i, .scan_sreq_i, .service_request_o, .first_miss_pulse_pin_o
);
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk_i = 1'h0, rst_n_i = 1'h0, go = 1'h0, alive = 1'h0, sreq = 1'h0, slow = 1'h0;
    logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
    logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
    logic [12:0] s_axi_awaddr_i = 13'h0000, s_axi_araddr_i = 13'h0000;
    logic [31:0] s_axi_wdata_i = 32'h00000000;
    logic [5:0] sat = 6'h00, s;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic scan_done_i, scan_reply_i, scan_sreq_i, busy, service_request_o;
    logic first_miss_pulse_pin_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
    logic [31:0] s_axi_rdata_o;
    logic [15:0] scan_data_i, d, w, x;
    logic [5:0] scan_sat_i;
    logic [3:0] scan_cmd_o;
    int n_errors = 0, cmp_count = 0, n, c;
    scw_ctrl_word #(.PULSE_CYCLES(16'h0004)) dut_u (
        .clk_i, .rst_n_i, .ce_i(1'h1), .s_axi_awaddr_i, .s_axi_awprot_i(3'h0),
        .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hf),
        .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arprot_i(3'h0), .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
        .scan_sel_i(scan_sat_i), .scan_cmd_o, .scan_done_i, .scan_sat_i, .scan_reply_i,
        .scan_data_i, .scan_sreq_i, .service_request_o, .first_miss_pulse_pin_o
    );
    scw_sat_model sat_u (
        .clk_i, .rst_n_i, .go_i(go), .sat_i(sat), .alive_i(alive), .sreq_i(sreq),
        .slow_i(slow), .scan_cmd_i(scan_cmd_o), .scan_sat_o(scan_sat_i),
        .scan_done_o(scan_done_i), .scan_reply_o(scan_reply_i), .scan_data_o(scan_data_i),
        .scan_sreq_o(scan_sreq_i), .busy_o(busy)
    );
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end
    function automatic [15:0] rdat(input [5:0] t, input [3:0] k);
        rdat = {k, 6'h00, t};
    endfunction
    // store place: image for 0/8, aux 7 for 7/15, aux 1-6 otherwise
    function automatic [10:0] store_ofs(input [5:0] t, input [3:0] k);
        logic [3:0] a;
        a = (k == 4'h0 || k == 4'h8) ? 4'h0 : (k == 4'h7 || k == 4'hf) ? 4'h7 :
            (k > 4'h8) ? k - 4'h8 : k;
        store_ofs = 11'h100 + {a, 7'h00} + {4'h0, t, 1'h0};
    endfunction
    function automatic [15:0] miss_word(input int m);
        logic [2:0] q;
        q = (m > 7) ? 3'h7 : m[2:0];
        miss_word = {1'h0, q, q >= 3'h3, q != 3'h0, 10'h000};
    endfunction
    task automatic final_report();
        $display("comparisons %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input [15:0] e, input [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop();
        chk("wait_bound", 16'h0001, 16'h0000);
        final_report();
    endtask
    task automatic wr(input [10:0] o, input [15:0] v);
        int i;
        logic got;
        begin
            got = 1'h0;
            s_axi_awaddr_i <= {o, 2'h0};
            s_axi_wdata_i <= {16'h0000, v};
            s_axi_awvalid_i <= 1'h1;
            s_axi_wvalid_i <= 1'h1;
            s_axi_bready_i <= 1'h1;
            for (i = 0; i < 20 && !got; i++)
            begin
                @(posedge clk_i);
                if (s_axi_awready_o)
                    s_axi_awvalid_i <= 1'h0;
                if (s_axi_wready_o)
                    s_axi_wvalid_i <= 1'h0;
                got = s_axi_bvalid_o;
            end
            if (!got)
                stop();
            chk("bresp", 16'h0000, {14'h0000, s_axi_bresp_o});
        end
    endtask
    task automatic rd(input [10:0] o, output [15:0] v, output [1:0] rs);
        int i;
        begin
            s_axi_araddr_i <= {o, 2'h0};
            s_axi_arvalid_i <= 1'h1;
            s_axi_rready_i <= 1'h1;
            for (i = 0; i < 20; i++)
            begin
                @(posedge clk_i);
                if (s_axi_arready_o)
                    s_axi_arvalid_i <= 1'h0;
                if (s_axi_rvalid_o)
                    break;
            end
            v = s_axi_rdata_o[15:0];
            rs = s_axi_rresp_o;
            if (i == 20)
                stop();
        end
    endtask
    task automatic rdc(input string nm, input [10:0] o, input [15:0] e);
        rd(o, d, r);
        chk(nm, e, d);
        chk("rresp", 16'h0000, {14'h0000, r});
    endtask
    // the model may stall, so wait on its busy flag rather than a fixed count
    task automatic scan(input [5:0] t, input a, input q);
        int i;
        begin
            sat <= t;
            alive <= a;
            sreq <= q;
            slow <= 1'($urandom % 2);
            go <= 1'h1;
            @(posedge clk_i);
            go <= 1'h0;
            for (i = 0; i < 20; i++)
            begin
                @(posedge clk_i);
                if (!busy)
                    break;
            end
            if (i == 20)
                stop();
        end
    endtask
    initial
    begin
        void'($urandom(5));
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        rdc("ctrl_reset", 11'h006, 16'h0000);
        rd(11'h000, d, r);
        chk("unmapped_resp", 16'h0002, {14'h0000, r});
        wr(11'h102, 16'h5a5a);
        for (n = 1; n <= 8; n++)
        begin
            scan(6'h01, 1'h0, 1'h0);
            if (n == 1)
                chk("first_miss_pin", 16'h0001, {15'h0000, first_miss_pulse_pin_o});
            rdc("miss_word", 11'h002, miss_word(n));
        end
        rdc("image_kept", 11'h102, 16'h5a5a);
        scan(6'h01, 1'h1, 1'h0);
        rdc("miss_clear", 11'h002, 16'h0000);
        rdc("image_new", 11'h102, rdat(6'h01, 4'h0));
        scan(6'h01, 1'h0, 1'h0);
        rdc("lost_once", 11'h002, 16'h1400);
        scan(6'h01, 1'h1, 1'h0);
        rdc("lost_cleared", 11'h002, 16'h0000);
        for (c = 0; c < 16; c++)
        begin
            s = 6'h01 + 6'($urandom % 63);
            w = 16'($urandom);
            wr(store_ofs(s, c[3:0]), w);
            wr({4'h0, s, 1'h0}, {12'h000, c[3:0]});
            scan(s, 1'h1, 1'h0);
            x = (c >= 1 && c <= 6) ? {12'h000, c[3:0]} : 16'h0000;
            rdc("cmd_after", {4'h0, s, 1'h0}, x);
            x = (c >= 9 && c <= 14) ? 16'h0000 : rdat(s, c[3:0]);
            rdc("stored", store_ofs(s, c[3:0]), x);
        end
        wr(11'h00a, 16'h0013);
        scan(6'h05, 1'h0, 1'h0);
        rdc("clear_waits", 11'h00a, 16'h1413);
        scan(6'h05, 1'h1, 1'h0);
        rdc("clear_done", 11'h00a, 16'h0000);
        wr(11'h00c, 16'h0030);
        for (c = 0; c < 7; c++)
        begin
            scan(6'h06, 1'h1, 1'h0);
            rdc("round_word", 11'h00c, (c < 6) ? 16'h0031 + c[15:0] : 16'h0000);
        end
        wr(11'h00c, 16'h0026);
        scan(6'h06, 1'h1, 1'h0);
        rdc("round_wrap", 11'h00c, 16'h0020);
        scan(6'h06, 1'h1, 1'h0);
        rdc("round_free", 11'h00c, 16'h0021);
        wr(11'h00e, 16'h0000);
        scan(6'h07, 1'h1, 1'h1);
        chk("req_pin", 16'h0001, {15'h0000, service_request_o});
        rdc("req_flag", 11'h00e, 16'h0100);
        wr(11'h00e, 16'h0001);
        scan(6'h07, 1'h1, 1'h0);
        rdc("req_served", 11'h00e, 16'h0001);
        chk("req_pin_holds", 16'h0001, {15'h0000, service_request_o});
        wr(11'h480, 16'h0000);
        chk("req_pin_clear", 16'h0000, {15'h0000, service_request_o});
        wr(11'h010, 16'hffff);
        rdc("ro_bits", 11'h010, 16'h00ff);
        final_report();
    end
endmodule
`default_nettype wire
